//--- pcc_top.sv
// Four-channel PWM controller: registers, shared clocks, channel counters
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcc_top
  import pcc_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              clk_en_in,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [DATA_W-1:0]      reg_rdata_out,
  // Channel outputs
  output logic [NUM_CH-1:0]      pwm_out,
  output logic                   irq_out
);
  typedef enum logic [1:0] {
    PCC_DIR_UP   = 2'b01,
    PCC_DIR_DOWN = 2'b10
  } pcc_dir_t;

  logic [31:0]      shared_clock_config;
  logic [31:0]      channel_config [NUM_CH];
  logic [CNT_W-1:0] channel_duty_value [NUM_CH];
  logic [CNT_W-1:0] channel_period_value [NUM_CH];
  logic [CNT_W-1:0] channel_counter_value [NUM_CH];
  logic [CNT_W-1:0] pending_update [NUM_CH];
  logic [NUM_CH-1:0] pending_valid;
  logic [NUM_CH-1:0] channel_enable_state;
  logic [NUM_CH-1:0] irq_mask_state;
  logic [NUM_CH-1:0] period_event_flags;
  logic [NUM_CH-1:0] period_end;
  logic [NUM_CH-1:0] ch_tick;
  pcc_dir_t          dir [NUM_CH];
  logic [10:0]      prescale_tick;
  logic             shared_clock_a;
  logic             shared_clock_b;
  logic [NUM_CH-1:0] hit_cfg;
  logic [NUM_CH-1:0] hit_duty;
  logic [NUM_CH-1:0] hit_period;
  logic [NUM_CH-1:0] hit_update;
  logic [DATA_W-1:0] next_rdata;
  logic             evt_read;
  logic             wr_en;

  assign wr_en = clk_en_in & reg_wr_in;
  assign evt_read = clk_en_in & reg_rd_in & (reg_addr_in == OFS_EVT_FLAGS);

  pcc_prescaler u_prescaler (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .clk_en_in  (clk_en_in),
    .tick_out   (prescale_tick)
  );

  pcc_shared_div u_shared_a (
    .ref_clk_in       (ref_clk_in),
    .rst_in           (rst_in),
    .clk_en_in        (clk_en_in),
    .source_select_in (shared_clock_config[SHARED_A_SOURCE_SELECT_LSB +: 4]),
    .divide_factor_in (shared_clock_config[SHARED_A_DIVIDE_FACTOR_LSB +: 8]),
    .prescale_tick_in (prescale_tick),
    .tick_out         (shared_clock_a)
  );

  pcc_shared_div u_shared_b (
    .ref_clk_in       (ref_clk_in),
    .rst_in           (rst_in),
    .clk_en_in        (clk_en_in),
    .source_select_in (shared_clock_config[SHARED_B_SOURCE_SELECT_LSB +: 4]),
    .divide_factor_in (shared_clock_config[SHARED_B_DIVIDE_FACTOR_LSB +: 8]),
    .prescale_tick_in (prescale_tick),
    .tick_out         (shared_clock_b)
  );

  // Shared clock configuration register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      shared_clock_config <= RESET_VALUE;
    end else if (wr_en && reg_addr_in == OFS_SHARED_CFG) begin
      shared_clock_config <= reg_wdata_in & SHARED_CFG_MASK;
    end
  end

  // Channel enable state; each write is applied in its own cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      channel_enable_state <= '0;
    end else if (wr_en && reg_addr_in == OFS_EN_SET) begin
      channel_enable_state <= channel_enable_state | reg_wdata_in[NUM_CH-1:0];
    end else if (wr_en && reg_addr_in == OFS_EN_CLR) begin
      channel_enable_state <= channel_enable_state & ~reg_wdata_in[NUM_CH-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_mask_state <= '0;
    end else if (wr_en && reg_addr_in == OFS_IRQ_SET) begin
      irq_mask_state <= irq_mask_state | reg_wdata_in[NUM_CH-1:0];
    end else if (wr_en && reg_addr_in == OFS_IRQ_CLR) begin
      irq_mask_state <= irq_mask_state & ~reg_wdata_in[NUM_CH-1:0];
    end
  end

  // Period-event flags: a new event wins over the clear-on-read
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      period_event_flags <= '0;
    end else if (clk_en_in) begin
      period_event_flags <= (evt_read ? '0 : period_event_flags) | period_end;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= |(period_event_flags & irq_mask_state);
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam logic [11:0] CH_BASE = OFS_CH_BASE + OFS_CH_STRIDE * 12'(ch);
      logic [3:0] src;
      logic       left_end;
      logic       center_end;
      logic       enable_hit;

      assign hit_cfg[ch]    = reg_addr_in == CH_BASE + OFS_CH_CFG;
      assign hit_duty[ch]   = reg_addr_in == CH_BASE + OFS_CH_DUTY;
      assign hit_period[ch] = reg_addr_in == CH_BASE + OFS_CH_PERIOD;
      assign hit_update[ch] = reg_addr_in == CH_BASE + OFS_CH_UPDATE;
      assign src = channel_config[ch][CHANNEL_CLOCK_SOURCE_LSB +: 4];
      assign enable_hit = wr_en & (reg_addr_in == OFS_EN_SET) & reg_wdata_in[ch];

      // Counter clock source selection
      always_comb begin
        if (src <= SRC_MAX_DIV) begin
          ch_tick[ch] = prescale_tick[src];
        end else if (src == SRC_SHARED_A) begin
          ch_tick[ch] = shared_clock_a;
        end else if (src == SRC_SHARED_B) begin
          ch_tick[ch] = shared_clock_b;
        end else begin
          ch_tick[ch] = 1'b0;
        end
      end

      assign left_end = channel_counter_value[ch] + 16'h0001 >= channel_period_value[ch];
      assign center_end = (dir[ch] == PCC_DIR_DOWN) && channel_counter_value[ch] <= 16'h0001;
      assign period_end[ch] = channel_enable_state[ch] & ch_tick[ch] & ~enable_hit &
                              (channel_config[ch][ALIGN_BIT] ? center_end : left_end);

      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          channel_config[ch] <= RESET_VALUE;
        end else if (wr_en && hit_cfg[ch]) begin
          channel_config[ch] <= reg_wdata_in & CH_CFG_MASK;
        end
      end

      // Duty, period and the double-buffered update value
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          channel_duty_value[ch]   <= '0;
          channel_period_value[ch] <= '0;
          pending_update[ch]       <= '0;
          pending_valid[ch]        <= 1'b0;
        end else if (clk_en_in) begin
          if (reg_wr_in && hit_duty[ch]) begin
            channel_duty_value[ch] <= reg_wdata_in[CNT_W-1:0];
          end else if (reg_wr_in && hit_period[ch]) begin
            channel_period_value[ch] <= reg_wdata_in[CNT_W-1:0];
          end
          if (reg_wr_in && hit_update[ch]) begin
            pending_update[ch] <= reg_wdata_in[CNT_W-1:0];
            pending_valid[ch]  <= 1'b1;
          end else if (pending_valid[ch] && (period_end[ch] || !channel_enable_state[ch])) begin
            pending_valid[ch] <= 1'b0;
            if (channel_config[ch][UPD_BIT]) begin
              channel_period_value[ch] <= pending_update[ch];
            end else begin
              channel_duty_value[ch] <= pending_update[ch];
            end
          end
        end
      end

      // Channel counter
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          channel_counter_value[ch] <= '0;
          dir[ch] <= PCC_DIR_UP;
        end else if (clk_en_in) begin
          if (enable_hit) begin
            channel_counter_value[ch] <= '0;
            dir[ch] <= PCC_DIR_UP;
          end else if (channel_enable_state[ch] && ch_tick[ch]) begin
            if (!channel_config[ch][ALIGN_BIT]) begin
              dir[ch] <= PCC_DIR_UP;
              if (left_end) begin
                channel_counter_value[ch] <= '0;
              end else begin
                channel_counter_value[ch] <= channel_counter_value[ch] + 16'h0001;
              end
            end else begin
              case (dir[ch])
                PCC_DIR_UP: begin
                  if (channel_counter_value[ch] + 16'h0001 >= channel_period_value[ch]) begin
                    dir[ch] <= PCC_DIR_DOWN;
                  end
                  channel_counter_value[ch] <= channel_counter_value[ch] + 16'h0001;
                end
                PCC_DIR_DOWN: begin
                  if (channel_counter_value[ch] <= 16'h0001) begin
                    dir[ch] <= PCC_DIR_UP;
                    channel_counter_value[ch] <= '0;
                  end else begin
                    channel_counter_value[ch] <= channel_counter_value[ch] - 16'h0001;
                  end
                end
                default: begin
                  dir[ch] <= PCC_DIR_UP;
                end
              endcase
            end
          end
        end
      end

      // Output: starting level while below duty, opposite level after
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          pwm_out[ch] <= 1'b0;
        end else if (clk_en_in) begin
          if (!channel_enable_state[ch]) begin
            pwm_out[ch] <= 1'b0;
          end else if (channel_counter_value[ch] < channel_duty_value[ch]) begin
            pwm_out[ch] <= channel_config[ch][POL_BIT];
          end else begin
            pwm_out[ch] <= ~channel_config[ch][POL_BIT];
          end
        end
      end
    end
  endgenerate

  // Read decode
  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (reg_addr_in == OFS_SHARED_CFG) begin
      next_rdata = shared_clock_config;
    end else if (reg_addr_in == OFS_EN_STATE) begin
      next_rdata = {{(DATA_W-NUM_CH){1'b0}}, channel_enable_state};
    end else if (reg_addr_in == OFS_IRQ_MASK) begin
      next_rdata = {{(DATA_W-NUM_CH){1'b0}}, irq_mask_state};
    end else if (reg_addr_in == OFS_EVT_FLAGS) begin
      next_rdata = {{(DATA_W-NUM_CH){1'b0}}, period_event_flags};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hit_cfg[i]) begin
          next_rdata = channel_config[i];
        end else if (hit_duty[i]) begin
          next_rdata = {16'h0000, channel_duty_value[i]};
        end else if (hit_period[i]) begin
          next_rdata = {16'h0000, channel_period_value[i]};
        end else if (reg_addr_in == OFS_CH_BASE + OFS_CH_STRIDE * 12'(i) + OFS_CH_COUNT) begin
          next_rdata = {16'h0000, channel_counter_value[i]};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (clk_en_in) begin
      reg_rdata_out <= reg_rd_in ? next_rdata : '0;
    end
  end
endmodule
`default_nettype wire

//--- pcc_pkg.sv
// Package of register map, field layout and constants for the PWM channel control block
package pcc_pkg;
  localparam int         NUM_CH        = 4;
  localparam int         CNT_W         = 16;
  localparam int         ADDR_W        = 12;
  localparam int         DATA_W        = 32;
  // Register byte offsets
  localparam logic [11:0] OFS_SHARED_CFG = 12'h000;
  localparam logic [11:0] OFS_EN_SET     = 12'h004;
  localparam logic [11:0] OFS_EN_CLR     = 12'h008;
  localparam logic [11:0] OFS_EN_STATE   = 12'h00c;
  localparam logic [11:0] OFS_IRQ_SET    = 12'h010;
  localparam logic [11:0] OFS_IRQ_CLR    = 12'h014;
  localparam logic [11:0] OFS_IRQ_MASK   = 12'h018;
  localparam logic [11:0] OFS_EVT_FLAGS  = 12'h01c;
  localparam logic [11:0] OFS_CH_BASE    = 12'h200;
  localparam logic [11:0] OFS_CH_STRIDE  = 12'h020;
  localparam logic [11:0] OFS_CH_CFG     = 12'h000;
  localparam logic [11:0] OFS_CH_DUTY    = 12'h004;
  localparam logic [11:0] OFS_CH_PERIOD  = 12'h008;
  localparam logic [11:0] OFS_CH_COUNT   = 12'h00c;
  localparam logic [11:0] OFS_CH_UPDATE  = 12'h010;
  // Shared clock configuration fields
  localparam int         SHARED_A_DIVIDE_FACTOR_LSB      = 0;
  localparam int         SHARED_A_SOURCE_SELECT_LSB      = 8;
  localparam int         SHARED_B_DIVIDE_FACTOR_LSB      = 16;
  localparam int         SHARED_B_SOURCE_SELECT_LSB      = 24;
  localparam logic [31:0] SHARED_CFG_MASK = 32'h0fff0fff;
  // Channel configuration fields
  localparam int         CHANNEL_CLOCK_SOURCE_LSB      = 0;
  localparam int         ALIGN_BIT     = 8;
  localparam int         POL_BIT       = 9;
  localparam int         UPD_BIT       = 10;
  localparam logic [31:0] CH_CFG_MASK   = 32'h0000070f;
  localparam logic [3:0] SRC_MAX_DIV   = 4'ha;
  localparam logic [3:0] SRC_SHARED_A  = 4'hb;
  localparam logic [3:0] SRC_SHARED_B  = 4'hc;
  localparam logic [31:0] RESET_VALUE   = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

//--- pcc_prescaler.sv
// Master-clock prescaler producing one-cycle ticks at divide-by-2^n rates
`timescale 1ns/1ps
`default_nettype none
module pcc_prescaler
  import pcc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        clk_en_in,
  // Tick outputs, bit n pulses once every 2^n cycles
  output logic [10:0]      tick_out
);
  logic [10:0] count;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      count <= 11'h000;
    end else if (clk_en_in) begin
      count <= count + 11'h001;
    end
  end

  // A bit of the tick fires when all lower count bits are ones
  genvar g;
  generate
    for (g = 0; g < 11; g++) begin : g_tick
      if (g == 0) begin : g_first
        assign tick_out[g] = clk_en_in;
      end else begin : g_rest
        assign tick_out[g] = clk_en_in & (&count[g-1:0]);
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- pcc_shared_div.sv
// Shared divided clock: prescaler tick selection followed by 8-bit divider
`timescale 1ns/1ps
`default_nettype none
module pcc_shared_div
  import pcc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        clk_en_in,
  // Configuration
  input  wire logic [3:0]  source_select_in,
  input  wire logic [7:0]  divide_factor_in,
  input  wire logic [10:0] prescale_tick_in,
  // Divided tick
  output logic             tick_out
);
  logic       src_tick;
  logic [7:0] count;

  always_comb begin
    if (source_select_in <= SRC_MAX_DIV) begin
      src_tick = prescale_tick_in[source_select_in];
    end else begin
      src_tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      count <= 8'h00;
    end else if (clk_en_in) begin
      if (divide_factor_in == 8'h00) begin
        count <= 8'h00;
      end else if (src_tick) begin
        if (count >= divide_factor_in - 8'h01) begin
          count <= 8'h00;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end

  // Zero factor stops the clock, one passes source, larger factors divide
  assign tick_out = (divide_factor_in != 8'h00) & src_tick &
                    (count >= divide_factor_in - 8'h01);
endmodule
`default_nettype wire

//--- pcc_top_assertions.sv
// Concurrent checks on the ports of the PWM channel control block
`timescale 1ns/1ps
`default_nettype none
module pcc_top_assertions
  import pcc_pkg::*;
(
  // Clock, reset, clock enable
  input wire logic              ref_clk_in,
  input wire logic              rst_in,
  input wire logic              clk_en_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  // Channel outputs
  input wire logic [NUM_CH-1:0] pwm_out,
  input wire logic              irq_out
);
  localparam logic [11:0] CH0_CNT = OFS_CH_BASE + OFS_CH_COUNT;
  logic [3:0] en_m;
  logic [3:0] msk_m;
  logic       wr_ok;
  logic       rd_ok;
  assign wr_ok = reg_wr_in && clk_en_in;
  assign rd_ok = reg_rd_in && clk_en_in;
  // Shadow of channel enables as software set them
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      en_m <= 4'h0;
    end else if (wr_ok && reg_addr_in == OFS_EN_SET) begin
      en_m <= en_m | reg_wdata_in[3:0];
    end else if (wr_ok && reg_addr_in == OFS_EN_CLR) begin
      en_m <= en_m & ~reg_wdata_in[3:0];
    end
  end
  // Shadow of interrupt mask as software set it
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      msk_m <= 4'h0;
    end else if (wr_ok && reg_addr_in == OFS_IRQ_SET) begin
      msk_m <= msk_m | reg_wdata_in[3:0];
    end else if (wr_ok && reg_addr_in == OFS_IRQ_CLR) begin
      msk_m <= msk_m & ~reg_wdata_in[3:0];
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_en_state;
    rd_ok && reg_addr_in == OFS_EN_STATE |=> reg_rdata_out == {28'h0, $past(en_m)};
  endproperty
  a_en_state: assert property (p_en_state) else $error("enable state read wrong");
  property p_mask_state;
    rd_ok && reg_addr_in == OFS_IRQ_MASK |=> reg_rdata_out == {28'h0, $past(msk_m)};
  endproperty
  a_mask_state: assert property (p_mask_state) else $error("mask read wrong");
  property p_flag_upper;
    rd_ok && reg_addr_in == OFS_EVT_FLAGS |=> reg_rdata_out[31:4] == 28'h0;
  endproperty
  a_flag_upper: assert property (p_flag_upper) else $error("flag read upper bits set");
  property p_shared_rsv;
    rd_ok && reg_addr_in == OFS_SHARED_CFG |=> (reg_rdata_out & ~SHARED_CFG_MASK) == 32'h0;
  endproperty
  a_shared_rsv: assert property (p_shared_rsv) else $error("shared cfg reserved bits");
  property p_ch_rsv;
    rd_ok && reg_addr_in == OFS_CH_BASE |=> (reg_rdata_out & ~CH_CFG_MASK) == 32'h0;
  endproperty
  a_ch_rsv: assert property (p_ch_rsv) else $error("channel cfg reserved bits");
  property p_pwm_off;
    (pwm_out & ~en_m & ~$past(en_m) & ~$past(en_m, 2)) == 4'h0;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("disabled channel drives high");
  property p_irq_off;
    msk_m == 4'h0 && $past(msk_m) == 4'h0 && $past(msk_m, 2) == 4'h0 |-> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
  property p_en_clears;
    (wr_ok && reg_addr_in == OFS_EN_SET && reg_wdata_in[0]) ##1
    (rd_ok && reg_addr_in == CH0_CNT) |=> reg_rdata_out == 32'h0;
  endproperty
  a_en_clears: assert property (p_en_clears) else $error("counter not cleared");
  property p_flag_clr;
    (rd_ok && reg_addr_in == OFS_EVT_FLAGS && en_m == 4'h0 && $past(en_m) == 4'h0 &&
     $past(en_m, 2) == 4'h0) ##1 (rd_ok && reg_addr_in == OFS_EVT_FLAGS)
    |=> reg_rdata_out == 32'h0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared by read");
  // Read data returns to zero after any enabled cycle without a read strobe
  property p_rdata_idle;
    clk_en_in && !reg_rd_in |=> reg_rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  // Clock enable low freezes every registered output
  property p_freeze;
    !clk_en_in |=> $stable(reg_rdata_out) && $stable(pwm_out) && $stable(irq_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while clock enable low");
endmodule
bind pcc_top pcc_top_assertions chk_u (
  .ref_clk_in    (ref_clk_in),
  .rst_in        (rst_in),
  .clk_en_in     (clk_en_in),
  .reg_addr_in   (reg_addr_in),
  .reg_wdata_in  (reg_wdata_in),
  .reg_wr_in     (reg_wr_in),
  .reg_rd_in     (reg_rd_in),
  .reg_rdata_out (reg_rdata_out),
  .pwm_out       (pwm_out),
  .irq_out       (irq_out)
);
`default_nettype wire

//--- tb_pcc_top.sv
// Self-checking testbench of the PWM channel control block
`timescale 1ns/1ps
`default_nettype none
module tb_pcc_top
  import pcc_pkg::*;
;
  logic        ref_clk_in   = 1'b0;
  logic        rst_in       = 1'b1;
  logic        clk_en_in    = 1'b1;
  logic [11:0] reg_addr_in  = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [3:0]  pwm_out;
  logic        irq_out;
  logic [31:0] d;
  int          fails        = 0;
  int          n_tests      = 0;
  int          cycles       = 0;
  pcc_top dut_u (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .clk_en_in     (clk_en_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .pwm_out       (pwm_out),
    .irq_out       (irq_out)
  );
  always #5 ref_clk_in = ~ref_clk_in;
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 650 cycles the run needs
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  // Read data is valid from the cycle after the strobe is taken until the next enabled cycle
  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
    chk(name, d, exp);
  endtask
  task automatic wrc(input string n, input logic [11:0] wa, input logic [31:0] v,
                     input logic [11:0] ra, input logic [31:0] exp);
    wr(wa, v);
    rdchk(n, ra, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  function automatic logic [11:0] ca(input int ch, input logic [11:0] o);
    return OFS_CH_BASE + 12'(ch) * OFS_CH_STRIDE + o;
  endfunction
  // Period 4 (upper half ignored), duty 1, only channel ch enabled
  task automatic start(input int ch, input logic [31:0] cfg);
    wr(OFS_EN_CLR, 32'hf);
    wr(ca(ch, OFS_CH_CFG), cfg);
    wr(ca(ch, OFS_CH_DUTY), 32'h1);
    wr(ca(ch, OFS_CH_PERIOD), 32'hffff0004);
    wr(OFS_EN_SET, 32'h1 << ch);
    idle(20);
  endtask
  // High cycles over a window spanning whole periods, phase independent
  task automatic wave(input string n, input int ch, input int len, input logic [31:0] exp);
    logic [31:0] h;
    h = 32'h0;
    repeat (len) begin
      @(posedge ref_clk_in);
      #1;
      h = h + {31'h0, pwm_out[ch]};
    end
    chk(n, h, exp);
  endtask
  task automatic t_regs;
    rdchk("en_rst", OFS_EN_STATE, 32'h0);
    rdchk("mask_rst", OFS_IRQ_MASK, 32'h0);
    rdchk("flags_rst", OFS_EVT_FLAGS, 32'h0);
    wrc("shared_cfg", OFS_SHARED_CFG, 32'hffffffff, OFS_SHARED_CFG, 32'h0fff0fff);
    wrc("ch_cfg", ca(1, OFS_CH_CFG), 32'hffffffff, ca(1, OFS_CH_CFG), 32'h0000070f);
    wrc("state_ro", OFS_EN_STATE, 32'hf, OFS_EN_STATE, 32'h0);
    wrc("unmapped", 12'h100, 32'hffffffff, 12'h100, 32'h0);
  endtask
  task automatic t_enable;
    wrc("set_a", OFS_EN_SET, 32'h5, OFS_EN_STATE, 32'h5);
    wrc("set_b", OFS_EN_SET, 32'h2, OFS_EN_STATE, 32'h7);
    wrc("clr_a", OFS_EN_CLR, 32'h1, OFS_EN_STATE, 32'h6);
    wr(OFS_EN_SET, 32'h8);
    wrc("last_clr", OFS_EN_CLR, 32'h8, OFS_EN_STATE, 32'h6);
    wr(OFS_EN_CLR, 32'h8);
    wrc("last_set", OFS_EN_SET, 32'h8, OFS_EN_STATE, 32'he);
    wrc("clr_all", OFS_EN_CLR, 32'hf, OFS_EN_STATE, 32'h0);
    wrc("irq_set", OFS_IRQ_SET, 32'h9, OFS_IRQ_MASK, 32'h9);
    wrc("irq_set2", OFS_IRQ_SET, 32'h2, OFS_IRQ_MASK, 32'hb);
    wrc("irq_clr", OFS_IRQ_CLR, 32'h8, OFS_IRQ_MASK, 32'h3);
    wrc("irq_clr2", OFS_IRQ_CLR, 32'hf, OFS_IRQ_MASK, 32'h0);
  endtask
  task automatic t_waves;
    start(0, 32'h0);
    wave("left_pol0", 0, 16, 32'd12);
    start(3, 32'h200);
    wave("left_pol1", 3, 16, 32'd4);
    start(1, 32'h1);
    wave("div2", 1, 16, 32'd12);
    wr(OFS_SHARED_CFG, 32'h00000101);
    start(0, 32'hb);
    wave("shared_a_div1", 0, 16, 32'd12);
    wr(OFS_SHARED_CFG, 32'h00000003);
    start(0, 32'hb);
    wave("shared_a_div3", 0, 48, 32'd36);
    wr(OFS_SHARED_CFG, 32'h01020000);
    start(2, 32'hc);
    wave("shared_b_div2", 2, 48, 32'd36);
    wr(OFS_SHARED_CFG, 32'h00000100);
    start(0, 32'hb);
    wave("shared_a_off", 0, 16, 32'd0);
    rdchk("count_off", ca(0, OFS_CH_COUNT), 32'h0);
  endtask
  // First read sees 20 ticks after enable: 0..3 left, or up to 4 and back centred
  task automatic t_count(input logic [31:0] cfg, input logic [31:0] exp);
    logic [31:0] mx;
    logic [31:0] e;
    int          p;
    mx = 32'h0;
    start(3, cfg);
    for (int j = 0; j < 12; j++) begin
      p = (j + 4) % 8;
      e = cfg[ALIGN_BIT] ? ((p <= 4) ? 32'(p) : 32'(8 - p)) : 32'(j % 4);
      rdchk("count_range", ca(3, OFS_CH_COUNT), e);
      if (d > mx) mx = d;
    end
    chk("count_max", mx, exp);
  endtask
  task automatic t_update;
    start(0, 32'h0);
    wr(ca(0, OFS_CH_UPDATE), 32'h3);
    idle(12);
    wave("upd_duty", 0, 16, 32'd4);
    wr(ca(0, OFS_CH_CFG), 32'h400);
    wr(ca(0, OFS_CH_UPDATE), 32'hffff0008);
    idle(20);
    wave("upd_period", 0, 16, 32'd10);
    wr(ca(0, OFS_CH_PERIOD), 32'd100);
    idle(30);
    wr(OFS_EN_CLR, 32'h1);
    idle(2);
    wr(OFS_EN_SET, 32'h1);
    rdchk("count_clear", ca(0, OFS_CH_COUNT), 32'h0);
  endtask
  // Every channel has run periods since the reset-time read of the flags
  task automatic t_events;
    wr(OFS_EN_CLR, 32'hf);
    idle(4);
    rdchk("flags_drain", OFS_EVT_FLAGS, 32'hf);
    start(2, 32'h0);
    chk("irq_masked", {31'h0, irq_out}, 32'h0);
    wr(OFS_IRQ_SET, 32'h4);
    idle(3);
    chk("irq_raised", {31'h0, irq_out}, 32'h1);
    wr(OFS_EN_CLR, 32'h4);
    idle(4);
    rdchk("flags_set", OFS_EVT_FLAGS, 32'h4);
    rdchk("flags_clr", OFS_EVT_FLAGS, 32'h0);
    idle(3);
    chk("irq_cleared", {31'h0, irq_out}, 32'h0);
    wr(OFS_IRQ_CLR, 32'hf);
  endtask
  // Clock enable low holds the read data and ignores a write
  task automatic t_freeze;
    wr(OFS_EN_SET, 32'h2);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= OFS_EN_STATE;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    clk_en_in <= 1'b0;
    wr(OFS_EN_CLR, 32'h2);
    idle(3);
    chk("frozen_rdata", reg_rdata_out, 32'h2);
    clk_en_in <= 1'b1;
    rdchk("frozen_write", OFS_EN_STATE, 32'h2);
    wr(OFS_EN_CLR, 32'h2);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    idle(1);
    t_regs();
    t_enable();
    t_waves();
    t_count(32'h0, 32'd3);
    t_count(32'h100, 32'd4);
    t_update();
    t_events();
    t_freeze();
    report_and_stop();
  end
endmodule
`default_nettype wire
